// ===== common/i2c_coll_map.svh
`ifndef I2C_COLL_MAP_SVH
`define I2C_COLL_MAP_SVH

// Register offsets on the plain register port
`define ADDR_W 8
`define DATA_W 8
`define OFS_CTRL 8'h00
`define OFS_RELOAD 8'h04
`define OFS_STATUS 8'h08
`define OFS_CLEAR 8'h0C
`define OFS_IRQ_EN 8'h10
`define OFS_LINES 8'h14

// master_control_reg fields
`define CTRL_RSTART_BIT 0
`define CTRL_STOP_BIT 1

// Status, clear and enable share one layout
`define EVT_W 3
`define EVT_COLLISION_BIT 0
`define EVT_RSTART_DONE_BIT 1
`define EVT_STOP_DONE_BIT 2

// Line status fields
`define LINES_SCL_BIT 0
`define LINES_SDA_BIT 1
`define LINES_BUSY_BIT 2

// Reset values
`define RST_RELOAD 8'h09
`define RST_IRQ_EN 3'h0
`define RST_STATUS 3'h0

// Timing
`define BAUD_W 8
`define SYNC_STAGES 2

`endif

// ===== common/i2c_coll_pkg.sv
`include "i2c_coll_map.svh"

package i2c_coll_pkg;

  typedef enum logic [9:0] {
    ST_IDLE = 10'b00_0000_0001,
    ST_RS_REL_SDA = 10'b00_0000_0010,
    ST_RS_CNT1 = 10'b00_0000_0100,
    ST_RS_WAIT_SCL = 10'b00_0000_1000,
    ST_RS_CNT2 = 10'b00_0001_0000,
    ST_RS_CNT3 = 10'b00_0010_0000,
    ST_SP_DRV_SDA = 10'b00_0100_0000,
    ST_SP_WAIT_SCL = 10'b00_1000_0000,
    ST_SP_CNT1 = 10'b01_0000_0000,
    ST_SP_CNT2 = 10'b10_0000_0000
  } seq_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } line_pair_t;

  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [`SYNC_STAGES-1:0] scl_sync;
    logic [`SYNC_STAGES-1:0] sda_sync;
    logic scl_prev;
    seq_state_t fsm;
    logic rs_en;
    logic sp_en;
    logic [`BAUD_W-1:0] reload;
    logic [`EVT_W-1:0] status;
    logic [`EVT_W-1:0] irq_en;
    line_pair_t drive;
    logic irq;
    logic [`DATA_W-1:0] rdata;
  } core_state_t;

endpackage

// ===== hdl/baud_counter.sv
`timescale 1ns/1ns
`default_nettype none
`include "i2c_coll_map.svh"

module baud_counter #(
  parameter int WIDTH = `BAUD_W
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire logic abort_in,
  input wire logic [WIDTH-1:0] reload_in,
  output logic expired_out,
  output logic running_out
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic active;
    logic expired;
  } bc_state_t;

  bc_state_t q, d;

  always_comb begin
    d = q;
    d.expired = 1'b0;
    if (abort_in) begin
      d.active = 1'b0;
      d.count = '0;
    end else if (load_in) begin
      d.active = 1'b1;
      d.count = reload_in;
    end else if (q.active) begin
      if (q.count == '0) begin
        // One pulse per rollover; the counter then idles
        d.expired = 1'b1;
        d.active = 1'b0;
      end else begin
        d.count = q.count - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expired_out = q.expired;
  assign running_out = q.active;

endmodule // baud_counter

`default_nettype wire

// ===== hdl/i2c_coll_master.sv
`timescale 1ns/1ns
`default_nettype none
`include "i2c_coll_map.svh"

// Contract
// [RQ1] Repeated start: SDA low when SCL rises is a collision.
// [RQ2] Repeated start: once released SDA is high, load and run baud counter.
// [RQ3] Then release SCL; when SCL high, SDA low means collision.
// [RQ4] Repeated start: SDA and SCL high reloads baud counter for a new count.
// [RQ5] SDA falling during that count is no collision; sequence continues.
// [RQ6] SCL falling during that count before SDA driven low is a collision.
// [RQ7] Both lines high at expiry: drive SDA low and reload counter.
// [RQ8] At end of final count drive SCL low; repeated start complete.
// [RQ9] Stop begins holding SDA low; once SDA low, release SCL.
// [RQ10] Stop: once SCL sampled high, load and run baud counter.
// [RQ11] Stop: after count with SDA released, SDA low is a collision.
// [RQ12] Stop: SCL low after release, before SDA rises, is a collision.
// [RQ13] Any collision sets collision flag and returns sequencer to idle.
// [RQ14] Collision aborts sequence, releases both lines, clears its enable bit.
// [RQ15] Software starts a stop by setting stop enable after a transfer.
// [RQ16] SDA and SCL are synchronised before any sampling decision.

module i2c_coll_master
  import i2c_coll_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [`ADDR_W-1:0] addr_in,
  input wire logic [`DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [`DATA_W-1:0] rdata_out,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [`DATA_W-1:0] pad_evt(input logic [`EVT_W-1:0] v);
    pad_evt = {{(`DATA_W-`EVT_W){1'b0}}, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  core_state_t q, d;
  reg_req_t req;
  line_pair_t line;
  logic scl_rise;
  logic bc_load;
  logic bc_abort;
  logic bc_expired;
  logic bc_running;
  logic collide;
  logic [`EVT_W-1:0] evt_set;
  logic [`EVT_W-1:0] evt_clr;

  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  // Decisions read only the second synchroniser stage
  assign line = '{scl: q.scl_sync[1], sda: q.sda_sync[1]}; // RQ16
  assign scl_rise = line.scl && !q.scl_prev;

  baud_counter #(
    .WIDTH(`BAUD_W)
  ) u_baud_counter (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .load_in(bc_load),
    .abort_in(bc_abort),
    .reload_in(q.reload),
    .expired_out(bc_expired),
    .running_out(bc_running)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    bc_load = 1'b0;
    bc_abort = 1'b0;
    collide = 1'b0;
    evt_set = '0;
    evt_clr = '0;

    d.scl_sync = {q.scl_sync[0], scl_in}; // RQ16
    d.sda_sync = {q.sda_sync[0], sda_in}; // RQ16
    d.scl_prev = line.scl;

    // Register writes
    if (req.wr) begin
      if (hit(req.addr, `OFS_CTRL) && q.fsm == ST_IDLE) begin
        // A second request while busy is dropped; repeated start has priority
        if (req.wdata[`CTRL_RSTART_BIT]) begin
          d.rs_en = 1'b1;
          d.fsm = ST_RS_REL_SDA;
          d.drive = '{scl: 1'b1, sda: 1'b0};
        end else if (req.wdata[`CTRL_STOP_BIT]) begin
          d.sp_en = 1'b1; // RQ15
          d.fsm = ST_SP_DRV_SDA;
          d.drive = '{scl: 1'b1, sda: 1'b1}; // RQ9
        end
      end
      if (hit(req.addr, `OFS_RELOAD)) begin
        d.reload = req.wdata[`BAUD_W-1:0];
      end
      if (hit(req.addr, `OFS_CLEAR)) begin
        evt_clr = req.wdata[`EVT_W-1:0];
      end
      if (hit(req.addr, `OFS_IRQ_EN)) begin
        d.irq_en = req.wdata[`EVT_W-1:0];
      end
    end

    // Sequencer
    unique case (q.fsm)
      ST_IDLE: begin
      end
      ST_RS_REL_SDA: begin
        if (line.sda) begin
          bc_load = 1'b1; // RQ2
          d.fsm = ST_RS_CNT1;
        end
      end
      ST_RS_CNT1: begin
        if (bc_expired) begin
          d.drive.scl = 1'b0; // RQ3
          d.fsm = ST_RS_WAIT_SCL;
        end
      end
      ST_RS_WAIT_SCL: begin
        // Stretched clock simply waits here
        if (scl_rise || line.scl) begin
          if (!line.sda) begin
            collide = 1'b1; // RQ1 RQ3
          end else begin
            bc_load = 1'b1; // RQ4
            d.fsm = ST_RS_CNT2;
          end
        end
      end
      ST_RS_CNT2: begin
        if (!line.scl) begin
          collide = 1'b1; // RQ6
        end else if (!line.sda) begin
          // Another master asserted first; no two can do it at once
          d.drive.sda = 1'b1; // RQ5
          bc_load = 1'b1; // RQ5
          d.fsm = ST_RS_CNT3;
        end else if (bc_expired) begin
          d.drive.sda = 1'b1; // RQ7
          bc_load = 1'b1; // RQ7
          d.fsm = ST_RS_CNT3;
        end
      end
      ST_RS_CNT3: begin
        // SCL level is deliberately not checked in this count
        if (bc_expired) begin
          d.drive.scl = 1'b1; // RQ8
          d.rs_en = 1'b0; // RQ8
          evt_set[`EVT_RSTART_DONE_BIT] = 1'b1;
          d.fsm = ST_IDLE;
        end
      end
      ST_SP_DRV_SDA: begin
        if (!line.sda) begin
          d.drive.scl = 1'b0; // RQ9
          d.fsm = ST_SP_WAIT_SCL;
        end
      end
      ST_SP_WAIT_SCL: begin
        if (line.scl) begin
          bc_load = 1'b1; // RQ10
          d.fsm = ST_SP_CNT1;
        end
      end
      ST_SP_CNT1: begin
        if (!line.scl) begin
          collide = 1'b1; // RQ12
        end else if (bc_expired) begin
          d.drive.sda = 1'b0;
          bc_load = 1'b1;
          d.fsm = ST_SP_CNT2;
        end
      end
      ST_SP_CNT2: begin
        if (bc_expired) begin
          if (!line.sda) begin
            collide = 1'b1; // RQ11
          end else begin
            d.sp_en = 1'b0;
            evt_set[`EVT_STOP_DONE_BIT] = 1'b1;
            d.fsm = ST_IDLE;
          end
        end
      end
      default: begin
        // Corrupted one-hot code recovers to idle with lines free
        d.fsm = ST_IDLE;
        d.drive = '{scl: 1'b0, sda: 1'b0};
        d.rs_en = 1'b0;
        d.sp_en = 1'b0;
        bc_abort = 1'b1;
      end
    endcase

    if (collide) begin
      evt_set[`EVT_COLLISION_BIT] = 1'b1; // RQ13
      d.fsm = ST_IDLE; // RQ13
      d.drive = '{scl: 1'b0, sda: 1'b0}; // RQ14
      d.rs_en = 1'b0; // RQ14
      d.sp_en = 1'b0; // RQ14
      bc_abort = 1'b1; // RQ14
    end

    // Set wins over a clear in the same cycle
    d.status = (q.status & ~evt_clr) | evt_set;
    d.irq = |(d.status & d.irq_en);

    // Read data valid only in the cycle after the strobe
    d.rdata = '0;
    if (req.rd) begin
      if (hit(req.addr, `OFS_CTRL)) begin
        d.rdata = {{(`DATA_W-2){1'b0}}, q.sp_en, q.rs_en};
      end else if (hit(req.addr, `OFS_RELOAD)) begin
        d.rdata = q.reload;
      end else if (hit(req.addr, `OFS_STATUS)) begin
        d.rdata = pad_evt(q.status);
      end else if (hit(req.addr, `OFS_IRQ_EN)) begin
        d.rdata = pad_evt(q.irq_en);
      end else if (hit(req.addr, `OFS_LINES)) begin
        d.rdata = {{(`DATA_W-3){1'b0}}, (q.fsm != ST_IDLE) | bc_running, line.sda, line.scl};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      q.scl_sync <= '1;
      q.sda_sync <= '1;
      q.scl_prev <= 1'b1;
      q.fsm <= ST_IDLE;
      q.rs_en <= 1'b0;
      q.sp_en <= 1'b0;
      q.reload <= `RST_RELOAD;
      q.status <= `RST_STATUS;
      q.irq_en <= `RST_IRQ_EN;
      q.drive <= '0;
      q.irq <= 1'b0;
      q.rdata <= '0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Open-drain: the pin value is always low, only the enable moves
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  assign scl_oe_out = q.drive.scl;
  assign sda_oe_out = q.drive.sda;
  assign irq_out = q.irq;
  assign rdata_out = q.rdata;

endmodule // i2c_coll_master

`default_nettype wire

// ===== sim/i2c_coll_master_assertions.sv
`timescale 1ns/1ns
`default_nettype none
`include "i2c_coll_map.svh"
module i2c_coll_checker (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_out,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic irq_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  ////////////////////////////////////////
  rd_idle_a:
    assert property (!rd_in |=> rdata_out == 8'h00) else $error("stray read data");
  clr_read_a:
    assert property (rd_in && addr_in == `OFS_CLEAR |=> rdata_out == 8'h00)
    else $error("clear reads back");
  reload_back_a:
    assert property (wr_in && addr_in == `OFS_RELOAD ##1 rd_in && addr_in == `OFS_RELOAD
      |=> rdata_out == $past(wdata_in, 2)) else $error("reload readback");
  pin_data_a:
    assert property (!scl_out && !sda_out) else $error("pin data high");
  rs_hold_a:
    assert property ($fell(scl_oe_out) && !sda_oe_out |=> !sda_oe_out [*3])
    else $error("sda driven early");
  sda_low_a:
    assert property ($rose(sda_oe_out) && !scl_oe_out |-> $past(scl_in, 4))
    else $error("sda driven without scl high");
  stop_rel_a:
    assert property ($fell(scl_oe_out) && sda_oe_out |-> $past(sda_oe_out) && !sda_in)
    else $error("scl freed early");
  rs_end_a:
    assert property ($rose(scl_oe_out) && $stable(sda_oe_out) && sda_oe_out
      |-> $past(sda_oe_out, 3)) else $error("final count skipped");
  rs_end_c: cover property ($rose(scl_oe_out) && sda_oe_out);
  stop_c: cover property ($fell(scl_oe_out) && sda_oe_out);
  irq_c: cover property ($rose(irq_out));
endmodule // i2c_coll_checker
`default_nettype wire

// ===== sim/i2c_bus_partner.sv
`timescale 1ns/1ns
`default_nettype none
// Other bus party; mode 0 quiet, 1 sda low while scl free,
// 2 grab scl in count, 3 sda low in count, 4 slow scl release
module i2c_bus_partner (
  input wire logic link_clk_in,
  input wire logic [2:0] mode_in,
  input wire logic scl_oe_in,
  input wire logic sda_oe_in,
  output logic scl_out,
  output logic sda_out
);
  logic scl_hold_q = 1'b0;
  logic sda_hold_q = 1'b0;
  logic scl_seen_q = 1'b0;
  logic armed_q = 1'b0;
  // Pull-ups: a released line reads high
  assign scl_out = !(scl_oe_in || scl_hold_q);
  assign sda_out = !(sda_oe_in || sda_hold_q || (mode_in == 3'h1 && !scl_oe_in));
  ////////////////////////////////////////
  // Two link edges of high scl keep it clear of the first sda check
  always @(posedge link_clk_in) begin
    scl_seen_q <= scl_out;
    // Idle lines are left alone; a grab then could stall a later stop forever
    armed_q <= mode_in == 3'h2 && (armed_q || scl_oe_in || sda_oe_in);
    case (mode_in)
      3'h2: scl_hold_q <= !scl_oe_in && armed_q && (scl_hold_q || (scl_out && scl_seen_q));
      3'h4: scl_hold_q <= scl_oe_in;
      default: scl_hold_q <= 1'b0;
    endcase
    sda_hold_q <= mode_in == 3'h3 && !scl_oe_in && (sda_hold_q || (scl_out && scl_seen_q));
  end
endmodule // i2c_bus_partner
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "i2c_coll_map.svh"
module testbench;
  logic clk_in = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic rd_seen = 1'b0;
  logic [2:0] mode = 3'h0;
  logic [7:0] rdata_out;
  logic scl_in, scl_oe_out, sda_in, sda_oe_out, irq_out;
  logic [15:0] exp_q[$];
  // Run code: status, ctrl, partner mode
  logic [7:0] runs [9] = '{8'h48, 8'h4c, 8'h4b, 8'h29, 8'h2a, 8'h90, 8'h94, 8'h31, 8'h32};
  logic [31:0] rnd = 32'h0000_c823;
  logic [7:0] r;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  initial begin
    #7;
    forever #200 link_clk = ~link_clk;
  end
  i2c_coll_master dut (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .scl_in(scl_in),
    .scl_out(),
    .scl_oe_out(scl_oe_out),
    .sda_in(sda_in),
    .sda_out(),
    .sda_oe_out(sda_oe_out),
    .irq_out(irq_out)
  );
  i2c_bus_partner peer (
    .link_clk_in(link_clk),
    .mode_in(mode),
    .scl_oe_in(scl_oe_out),
    .sda_oe_in(sda_oe_out),
    .scl_out(scl_in),
    .sda_out(sda_in)
  );
  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Strobes stay up between back-to-back cycles; idle drops them
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    wr_in <= w;
    rd_in <= !w;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back({m, e});
    bus(1'b0, a, 8'h00);
  endtask
  task automatic idle(input int k);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    repeat (k) @(posedge clk_in);
  endtask
  always @(posedge clk_in) begin
    rd_seen <= rd_in;
    cycles++;
    if (rd_seen) begin
      chk(rdata_out & exp_q[0][15:8], exp_q[0][7:0]);
      void'(exp_q.pop_front());
    end
    if (cycles == 30000) begin
      fails++;
      end_sim();
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_in);
    reset_n_in <= 1'b1;
    idle(3);
    rd(`OFS_RELOAD, 8'h09, 8'hff);
    rd(`OFS_IRQ_EN, 8'h00, 8'hff);
    rd(`OFS_STATUS, 8'h00, 8'hff);
    rd(`OFS_CLEAR, 8'h00, 8'hff);
    rd(8'h20, 8'h00, 8'hff);
    rd(`OFS_LINES, 8'h03, 8'hff);
    foreach (runs[i]) begin
      rnd = xs(rnd);
      r = {4'h1, rnd[3:0]};
      mode <= runs[i][2:0];
      bus(1'b1, `OFS_IRQ_EN, 8'h07);
      bus(1'b1, `OFS_RELOAD, r);
      rd(`OFS_RELOAD, r, 8'hff);
      bus(1'b1, `OFS_CTRL, {6'h00, runs[i][4:3]});
      // Busy sequencer must ignore this one
      bus(1'b1, `OFS_CTRL, {6'h00, ~runs[i][4:3]});
      rd(`OFS_LINES, 8'h04, 8'h04);
      n = 0;
      while (irq_out !== 1'b1 && n < 3000) begin
        idle(1);
        n++;
      end
      chk({7'h00, irq_out}, 8'h01);
      rd(`OFS_STATUS, {5'h00, runs[i][7:5]}, 8'hff);
      rd(`OFS_CTRL, 8'h00, 8'h03);
      mode <= 3'h0;
      bus(1'b1, `OFS_IRQ_EN, {5'h00, ~runs[i][7:5]});
      idle(3);
      chk({7'h00, irq_out}, 8'h00);
      bus(1'b1, `OFS_CLEAR, 8'h07);
      rd(`OFS_STATUS, 8'h00, 8'hff);
      idle(3);
    end
    end_sim();
  end
endmodule // testbench
bind i2c_coll_master i2c_coll_checker chk_i (
  .clk_in(clk_in),
  .reset_n_in(reset_n_in),
  .addr_in(addr_in),
  .wdata_in(wdata_in),
  .wr_in(wr_in),
  .rd_in(rd_in),
  .rdata_out(rdata_out),
  .scl_in(scl_in),
  .scl_out(scl_out),
  .scl_oe_out(scl_oe_out),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe_out(sda_oe_out),
  .irq_out(irq_out)
);
`default_nettype wire
